// ### bench/radio_far_end.sv
// Model of the remote radios and the air beside the sequencer.
// Assumes tb_top calls send for packets heard in receive mode.
`timescale 1ns/10ps
`default_nettype none
module radio_far_end (
  input wire logic clk,
  input wire logic radio_tx_on,
  input wire logic answer,
  input wire logic [39:0] reply_addr,
  output logic [39:0] rx_addr_in,
  output logic rx_addr_valid,
  output logic rx_packet_end,
  output logic rx_crc_ok,
  output logic rx_skip_ack,
  output logic rx_ack_has_payload,
  output logic tx_done
);
  initial begin
    rx_addr_in = 40'h0;
    rx_addr_valid = 1'b0;
    rx_packet_end = 1'b0;
    rx_crc_ok = 1'b0;
    rx_skip_ack = 1'b0;
    rx_ack_has_payload = 1'b0;
    tx_done = 1'b0;
  end
  // ==========================================
  // One frame: address pulse, then end five cycles later
  task automatic send(input logic [39:0] a, input logic skip, input logic pay = 1'b0);
    rx_addr_in <= a;
    rx_addr_valid <= 1'b1;
    @(posedge clk);
    rx_addr_valid <= 1'b0;
    // Released line shows the inverse so a stale value cannot match
    rx_addr_in <= ~a;
    repeat (4) @(posedge clk);
    rx_packet_end <= 1'b1;
    rx_crc_ok <= 1'b1;
    rx_skip_ack <= skip;
    rx_ack_has_payload <= pay;
    @(posedge clk);
    rx_packet_end <= 1'b0;
    rx_crc_ok <= 1'b0;
    rx_skip_ack <= 1'b0;
    rx_ack_has_payload <= 1'b0;
  endtask
  // ==========================================
  // Air time of our own sends, and an optional acknowledgement
  initial forever begin
    @(posedge clk iff radio_tx_on);
    repeat (5) @(posedge clk);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    if (answer) begin
      repeat (2) @(posedge clk);
      send(reply_addr, 1'b0);
    end
  end
endmodule
`default_nettype wire

// ### bench/radio_link_properties.sv
// Port checker for the link sequencer.
// Assumes a bind from tb_top and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module radio_link_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rx_addr_valid,
  input wire logic rx_packet_end,
  input wire logic tx_done,
  input wire logic tx_fifo_pop,
  input wire logic rx_fifo_push,
  input wire logic [2:0] rx_fifo_pipe,
  input wire logic radio_tx_on,
  input wire logic radio_rx_on,
  input wire logic radio_interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Sequences
  sequence read_start;
    $rose(avs_read);
  endsequence
  sequence heard_addr;
    radio_rx_on && rx_addr_valid && !rx_packet_end;
  endsequence
  // ==========================================
  // Properties
  read_wait_a: assert property (read_start |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");
  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  half_duplex_a: assert property (!(radio_tx_on && radio_rx_on))
    else $error("transmit and receive on together");
  push_at_end_a: assert property (rx_fifo_push |-> rx_packet_end)
    else $error("receive push away from packet end");
  push_irq_a: assert property (rx_fifo_push |-> ##[0:2] radio_interrupt)
    else $error("no interrupt after receive");
  pop_irq_a: assert property (tx_fifo_pop |-> rx_packet_end ##[0:2] radio_interrupt)
    else $error("drop without ack end or interrupt");
  hold_rx_a: assert property (heard_addr |=> radio_rx_on [*5])
    else $error("receive left during packet");
  listen_after_a: assert property (radio_tx_on && tx_done |-> ##[1:3] radio_rx_on)
    else $error("no receive after send");
  pipe_range_a: assert property (rx_fifo_push |-> rx_fifo_pipe <= 3'h5)
    else $error("pipe number out of range");
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the link sequencer.
// Assumes radio_link_pkg is compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int settle_n = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b1;
  logic [5:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, tx_fifo_nonempty, answer;
  logic [31:0] avs_writedata, avs_readdata, rdata, seed;
  logic [39:0] rx_addr_in, tx_dest_addr, reply_addr, a0, ta;
  logic rx_addr_valid, rx_packet_end, rx_crc_ok, rx_skip_ack, rx_ack_has_payload, tx_done;
  logic tx_fifo_pop, rx_fifo_push, radio_tx_on, radio_rx_on, crc_forced_on, radio_interrupt;
  logic [2:0] rx_fifo_pipe, last_pipe;
  logic prev_tx = 1'b0;
  int fail_count = 0;
  int checked = 0;
  int pushes = 0;
  int pops = 0;
  int starts = 0;
  int k, s0;
  always #2.5 clk = ~clk;
  radio_link #(.settle_count(settle_n), .ce_min_count(4), .retry_step_count(10)) uut (
    .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .rx_addr_in, .rx_addr_valid, .rx_packet_end, .rx_crc_ok, .rx_skip_ack,
    .rx_ack_has_payload, .tx_done, .tx_fifo_nonempty, .tx_fifo_pop, .rx_fifo_push,
    .rx_fifo_pipe, .radio_tx_on, .radio_rx_on, .crc_forced_on, .tx_dest_addr, .radio_interrupt);
  radio_far_end far (.clk, .radio_tx_on, .answer, .reply_addr, .rx_addr_in, .rx_addr_valid,
    .rx_packet_end, .rx_crc_ok, .rx_skip_ack, .rx_ack_has_payload, .tx_done);
  always @(posedge clk) begin
    pushes += rx_fifo_push;
    pops += tx_fifo_pop;
    starts += (radio_tx_on & ~prev_tx);
    prev_tx = radio_tx_on;
    if (rx_fifo_push) last_pipe = rx_fifo_pipe;
  end
  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [39:0] pipe_addr(input logic [31:0] up, input logic [7:0] lsb);
    return {up, lsb};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Waitrequest is looked at mid-cycle, where it is settled for the next rising edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(negedge clk);
    while (avs_waitrequest) @(negedge clk);
    @(posedge clk);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    @(negedge clk);
    while (avs_waitrequest) @(negedge clk);
    @(posedge clk);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_hi(ref logic s, input int n);
    k = 0;
    @(negedge clk);
    while (s !== 1'b1 && k < n) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
  // ==========================================
  // Main sequence
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {tx_fifo_nonempty, answer, reply_addr} = '0;
    seed = 32'h27258637;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(radio_link_pkg::pipe_enable_off);
    check(rdata, 32'h3);
    rd(6'h3c);
    check(rdata, 32'h0);
    check(tx_dest_addr, radio_link_pkg::pipe_zero_reset);
    $display("test reset done");
    seed = lfsr(seed);
    a0 = {seed[7:0], seed};
    wr(radio_link_pkg::pipe_zero_addr_lo_off, a0[31:0]);
    wr(radio_link_pkg::pipe_zero_addr_hi_off, {24'h0, a0[39:32]});
    wr(radio_link_pkg::pipe_enable_off, 32'h0);
    wr(radio_link_pkg::control_off, 32'h7);
    check(crc_forced_on, 1'b1);
    wait_hi(radio_rx_on, 100);
    far.send(a0, 1'b0);
    repeat (10) @(posedge clk);
    check(pushes, 0);
    wr(radio_link_pkg::pipe_enable_off, 32'h1);
    far.send(a0, 1'b0);
    wait_hi(radio_tx_on, 20);
    check(k < 20, 1'b1);
    check(tx_dest_addr, a0);
    check({pushes, 5'h0, last_pipe}, {32'h1, 8'h0});
    rd(radio_link_pkg::status_off);
    check(rdata[0], 1'b1);
    check(radio_interrupt, 1'b1);
    wr(radio_link_pkg::status_off, 32'h7);
    wait_hi(radio_rx_on, 50);
    s0 = starts;
    far.send(a0, 1'b1);
    repeat (12) @(posedge clk);
    check({pushes, starts}, {32'h2, s0});
    // Distinct low bytes keep every pipe unique
    seed = lfsr(seed);
    wr(radio_link_pkg::shared_addr_off, seed);
    wr(radio_link_pkg::pipe_lsb_off, 32'h44332211);
    wr(radio_link_pkg::pipe_enable_off, 32'h3f);
    far.send(pipe_addr(seed, 8'h33), 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    check(last_pipe, 3'h3);
    check(tx_dest_addr, pipe_addr(seed, 8'h33));
    wait_hi(radio_rx_on, 50);
    rd(radio_link_pkg::status_off);
    check(rdata[1], 1'b0);
    far.send(pipe_addr(seed, 8'h33), 1'b0);
    wait_hi(radio_tx_on, 20);
    rd(radio_link_pkg::status_off);
    check(rdata[1], 1'b1);
    $display("test receiver done");
    wait_hi(radio_rx_on, 50);
    // Chip enable drops while still a receiver, so the sequencer goes idle first
    wr(radio_link_pkg::control_off, 32'h6);
    wr(radio_link_pkg::status_off, 32'h7);
    wr(radio_link_pkg::wait_cfg_off, 32'h31);
    seed = lfsr(seed);
    ta = {seed[15:8], seed};
    reply_addr <= ta;
    wr(radio_link_pkg::tx_addr_lo_off, ta[31:0]);
    wr(radio_link_pkg::tx_addr_hi_off, {24'h0, ta[39:32]});
    wr(radio_link_pkg::pipe_zero_addr_lo_off, ta[31:0]);
    wr(radio_link_pkg::pipe_zero_addr_hi_off, {24'h0, ta[39:32]});
    tx_fifo_nonempty <= 1'b1;
    repeat (30) @(posedge clk);
    wr(radio_link_pkg::control_off, 32'h5);
    wait_hi(radio_tx_on, settle_n + 10);
    check(k >= settle_n - 3 && k <= settle_n + 3, 1'b1);
    wait_hi(radio_rx_on, 20);
    check(k < 20, 1'b1);
    answer <= 1'b1;
    wait_hi(radio_tx_on, 300);
    check({k < 300, pops}, {1'b1, 32'h0});
    wait_hi(tx_fifo_pop, 100);
    tx_fifo_nonempty <= 1'b0;
    repeat (3) @(posedge clk);
    check(pops, 1);
    rd(radio_link_pkg::status_off);
    check({rdata[2:0], radio_interrupt}, 4'h5);
    $display("test transmitter done");
    final_report();
  end
endmodule
bind radio_link radio_link_properties chk (.clk, .reset_n, .avs_read, .avs_write,
  .avs_waitrequest, .rx_addr_valid, .rx_packet_end, .tx_done, .tx_fifo_pop, .rx_fifo_push,
  .rx_fifo_pipe, .radio_tx_on, .radio_rx_on, .radio_interrupt);
`default_nettype wire

// ### design/radio_link.sv
// Auto-acknowledge link sequencer with six receive pipes and retransmission.
// Assumes an Avalon-MM master with waitrequest and a radio front end that
// flags address matches, packet ends and transmit completion as pulses.
//
// Overview of operation
// RULE1 - Receiver offers six logical pipes on one channel, each with own address.
// RULE2 - Incoming address compared against all enabled pipes at the same time.
// RULE3 - While one pipe receives, no other pipe may start until packet ends.
// RULE4 - CRC, width, channel, rate, gain shared; CRC forced on with auto ack.
// RULE5 - Each pipe has its own enable bit; pipes 0 and 1 enabled after reset.
// RULE6 - Pipe 0 has full address; pipes 1-5 share four upper bytes.
// RULE7 - Controller must give every pipe a distinct address.
// RULE8 - Acknowledgement destination is the address of the accepting pipe.
// RULE9 - Transmitter software sets destination and pipe 0 address equal.
// RULE10 - Every autonomous sequence ends by raising the radio interrupt; none if the final send gets a bad-CRC reply before its timer ends.
// RULE11 - Chip enable held at least 10 us; sending starts 130 us later.
// RULE12 - After a send expecting acknowledgement, switch to receive and wait.
// RULE13 - Receiver raises interrupt on a packet, then sends the acknowledgement.
// RULE14 - Transmitter on acknowledgement raises interrupt and drops the packet.
// RULE15 - Receive-ready on packet; data-sent on transmitter only after acknowledgement.
// RULE16 - No acknowledgement in the wait slot means the same packet is resent.
// RULE17 - Address match during wait keeps receive mode until packet ends.
// RULE18 - Receiver data-sent for payload acknowledgement waits for next packet.
// RULE19 - Several transmitters should use differing retransmit delays.
// RULE20 - Controller waits at least 130 us between transactions.
// RULE21 - Controller starts operation by raising the chip enable bit.
// RULE22 - No acknowledgement for a packet with skip-acknowledge set.
// RULE23 - Packets matching only disabled pipes are ignored completely; in transmit mode any address is taken while awaiting acknowledgement.
`timescale 1ns/10ps
`default_nettype none
module radio_link #(
  parameter int settle_count = radio_link_pkg::settle_cycles,
  parameter int ce_min_count = radio_link_pkg::ce_min_cycles,
  parameter int retry_step_count = radio_link_pkg::retry_step_cycles
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [39:0] rx_addr_in,
  input wire logic rx_addr_valid,
  input wire logic rx_packet_end,
  input wire logic rx_crc_ok,
  input wire logic rx_skip_ack,
  input wire logic rx_ack_has_payload,
  input wire logic tx_done,
  input wire logic tx_fifo_nonempty,
  output logic tx_fifo_pop,
  output logic rx_fifo_push,
  output logic [2:0] rx_fifo_pipe,
  output logic radio_tx_on,
  output logic radio_rx_on,
  output logic crc_forced_on,
  output logic [39:0] tx_dest_addr,
  output logic radio_interrupt
);
  import radio_link_pkg::*;
  // ==========================================
  // Register file
  logic [31:0] radio_control_reg;
  logic [5:0] pipe_enable_bits;
  logic [39:0] pipe_zero_rx_address;
  logic [31:0] shared_upper;
  logic [7:0] pipe_lsb [1:5];
  logic [39:0] tx_addr;
  logic [39:0] ack_addr;
  logic [3:0] retransmit_delay;
  logic [3:0] retry_limit;
  logic rx_data_ready_irq, tx_data_sent_irq, max_retry_irq;
  logic [2:0] last_pipe;
  logic rd_phase;
  link_state_type state;
  logic [31:0] timer;
  logic [3:0] retry_count;
  logic [2:0] cur_pipe;
  logic pending_payload_ack;
  logic ce_ok;
  logic [31:0] ce_count;
  logic set_rx, set_tx, set_max;
  logic [5:0] match;
  logic match_any;
  logic [2:0] match_pipe;
  logic bus_wr;
  // Full address of one pipe; pipes 1-5 built from the shared bytes
  function automatic logic [39:0] pipe_address(input logic [2:0] p, input logic [39:0] p0,
      input logic [31:0] up, input logic [7:0] lsb);
    pipe_address = (p == 3'h0) ? p0 : {up, lsb}; // RULE6
  endfunction
  // Lowest set bit to pipe number; distinct addresses make it one-hot
  function automatic logic [2:0] pipe_index(input logic [5:0] m);
    pipe_index = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (m[i]) begin
        pipe_index = 3'(i);
      end
    end
  endfunction
  // ==========================================
  // Parallel address compare
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      match[i] = pipe_enable_bits[i] && // RULE5 RULE23
        (rx_addr_in == pipe_address(3'(i), pipe_zero_rx_address, shared_upper,
        pipe_lsb[(i == 0) ? 1 : i])); // RULE1 RULE2
    end
  end
  assign match_any = |match;
  assign match_pipe = pipe_index(match);
  // ==========================================
  // Avalon slave: one wait cycle on reads, writes taken at once
  assign bus_wr = avs_write;
  assign avs_waitrequest = avs_read && !rd_phase;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_phase <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_phase <= avs_read && !rd_phase;
      if (avs_read && !rd_phase) begin
        case (avs_address)
          control_off: avs_readdata <= radio_control_reg;
          pipe_enable_off: avs_readdata <= {26'h0, pipe_enable_bits};
          pipe_zero_addr_lo_off: avs_readdata <= pipe_zero_rx_address[31:0];
          pipe_zero_addr_hi_off: avs_readdata <= {24'h0, pipe_zero_rx_address[39:32]};
          shared_addr_off: avs_readdata <= shared_upper;
          pipe_lsb_off: avs_readdata <= {pipe_lsb[4], pipe_lsb[3], pipe_lsb[2], pipe_lsb[1]};
          tx_addr_lo_off: avs_readdata <= tx_addr[31:0];
          tx_addr_hi_off: avs_readdata <= {24'h0, tx_addr[39:32]};
          status_off: avs_readdata <= {pipe_lsb[5], 17'h0, last_pipe, 1'b0,
            max_retry_irq, tx_data_sent_irq, rx_data_ready_irq};
          ack_addr_lo_off: avs_readdata <= ack_addr[31:0];
          ack_addr_hi_off: avs_readdata <= {24'h0, ack_addr[39:32]};
          wait_cfg_off: avs_readdata <= {24'h0, retry_limit, retransmit_delay};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      radio_control_reg <= control_reset;
      pipe_enable_bits <= pipe_enable_reset; // RULE5
      pipe_zero_rx_address <= pipe_zero_reset;
      shared_upper <= shared_reset;
      for (int i = 1; i <= 5; i++) begin
        pipe_lsb[i] <= pipe_lsb_reset + 8'(i - 1);
      end
      tx_addr <= pipe_zero_reset;
      retransmit_delay <= wait_cfg_reset[3:0];
      retry_limit <= wait_cfg_reset[7:4];
    end else if (bus_wr) begin
      case (avs_address)
        control_off: radio_control_reg <= {28'h0, avs_writedata[3:0]}; // RULE21
        pipe_enable_off: pipe_enable_bits <= avs_writedata[5:0];
        pipe_zero_addr_lo_off: pipe_zero_rx_address[31:0] <= avs_writedata;
        pipe_zero_addr_hi_off: pipe_zero_rx_address[39:32] <= avs_writedata[7:0];
        shared_addr_off: shared_upper <= avs_writedata;
        pipe_lsb_off: begin
          for (int i = 1; i <= 4; i++) begin
            pipe_lsb[i] <= avs_writedata[8*i-8 +: 8];
          end
        end
        status_off: pipe_lsb[5] <= avs_writedata[31:24];
        tx_addr_lo_off: tx_addr[31:0] <= avs_writedata;
        tx_addr_hi_off: tx_addr[39:32] <= avs_writedata[7:0];
        wait_cfg_off: begin
          retransmit_delay <= avs_writedata[3:0];
          retry_limit <= avs_writedata[7:4];
        end
        default: ;
      endcase
    end
  end
  // ==========================================
  // Sticky flags: hardware set wins over a write-one clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_data_ready_irq <= 1'b0;
      tx_data_sent_irq <= 1'b0;
      max_retry_irq <= 1'b0;
    end else begin
      rx_data_ready_irq <= set_rx || (rx_data_ready_irq &&
        !(bus_wr && avs_address == status_off && avs_writedata[st_rx_data_ready]));
      tx_data_sent_irq <= set_tx || (tx_data_sent_irq &&
        !(bus_wr && avs_address == status_off && avs_writedata[st_tx_data_sent]));
      max_retry_irq <= set_max || (max_retry_irq &&
        !(bus_wr && avs_address == status_off && avs_writedata[st_max_retry]));
    end
  end
  assign radio_interrupt = rx_data_ready_irq | tx_data_sent_irq | max_retry_irq; // RULE10
  assign crc_forced_on = radio_control_reg[ctl_crc_on] | radio_control_reg[ctl_auto_ack]; // RULE4
  // ==========================================
  // Chip enable hold time
  // Count is kept outside idle so a drop after the minimum hold does not abort
  assign ce_ok = ce_count >= 32'(ce_min_count); // RULE11
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ce_count <= 32'h0;
    end else if (state == st_idle && !radio_control_reg[ctl_chip_enable]) begin
      ce_count <= 32'h0;
    end else if (radio_control_reg[ctl_chip_enable] && ce_count < 32'(ce_min_count)) begin
      ce_count <= ce_count + 32'h1;
    end
  end
  // ==========================================
  // Transaction sequencer
  always_comb begin
    set_rx = 1'b0;
    set_tx = 1'b0;
    set_max = 1'b0;
    if (state == st_receive && rx_packet_end && rx_crc_ok) begin
      // An empty acknowledgement on the transmitter raises data-sent only
      set_rx = radio_control_reg[ctl_primary_rx] || rx_ack_has_payload; // RULE13 RULE15
      if (radio_control_reg[ctl_primary_rx]) begin
        set_tx = pending_payload_ack; // RULE18
      end else begin
        set_tx = 1'b1; // RULE14 RULE15
      end
    end
    if (state == st_backoff && timer == 32'h0 && retry_count >= retry_limit) begin
      set_max = 1'b1; // RULE10
    end
  end
  assign tx_fifo_pop = state == st_receive && rx_packet_end && rx_crc_ok &&
    !radio_control_reg[ctl_primary_rx]; // RULE14
  assign rx_fifo_push = state == st_receive && rx_packet_end && rx_crc_ok &&
    radio_control_reg[ctl_primary_rx];
  assign radio_tx_on = state == st_send || state == st_ack_send;
  assign radio_rx_on = state == st_listen || state == st_receive;
  assign rx_fifo_pipe = cur_pipe;
  assign tx_dest_addr = (state == st_ack_send) ? ack_addr : tx_addr; // RULE8 RULE9
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
      timer <= 32'h0;
      retry_count <= 4'h0;
      cur_pipe <= 3'h0;
      last_pipe <= 3'h0;
      ack_addr <= 40'h0;
      pending_payload_ack <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (radio_control_reg[ctl_primary_rx] && radio_control_reg[ctl_chip_enable]) begin
            state <= st_settle;
            timer <= 32'(settle_count);
          end else if (radio_control_reg[ctl_chip_enable] && tx_fifo_nonempty) begin
            state <= st_settle;
            timer <= 32'(settle_count); // RULE11
            retry_count <= 4'h0;
          end
        end
        st_settle: begin
          // Settling runs from the rise of chip enable; a too short pulse aborts only in transmit mode
          if (!radio_control_reg[ctl_primary_rx] && !radio_control_reg[ctl_chip_enable] &&
              !ce_ok) begin
            state <= st_idle; // RULE11
          end else if (timer != 32'h0) begin
            timer <= timer - 32'h1;
          end else begin
            state <= radio_control_reg[ctl_primary_rx] ? st_listen : st_send;
          end
        end
        st_send: begin
          if (tx_done) begin
            state <= st_listen; // RULE12
            timer <= 32'(retry_step_count) * (32'(retransmit_delay) + 32'h1);
          end
        end
        st_listen: begin
          if (!radio_control_reg[ctl_chip_enable] && radio_control_reg[ctl_primary_rx]) begin
            state <= st_idle;
          end else if (rx_addr_valid && (match_any || !radio_control_reg[ctl_primary_rx])) begin
            state <= st_receive; // RULE3 RULE17 RULE23
            cur_pipe <= match_pipe;
            ack_addr <= pipe_address(match_pipe, pipe_zero_rx_address, shared_upper,
              pipe_lsb[(match_pipe == 3'h0) ? 3'h1 : match_pipe]); // RULE8
          end else if (!radio_control_reg[ctl_primary_rx]) begin
            if (timer != 32'h0) begin
              timer <= timer - 32'h1;
            end else begin
              state <= st_backoff; // RULE16
            end
          end
        end
        st_receive: begin
          if (rx_packet_end) begin
            if (!rx_crc_ok) begin
              state <= radio_control_reg[ctl_primary_rx] ? st_listen : st_backoff;
            end else if (radio_control_reg[ctl_primary_rx]) begin
              last_pipe <= cur_pipe;
              pending_payload_ack <= 1'b0;
              state <= (radio_control_reg[ctl_auto_ack] && !rx_skip_ack)
                ? st_ack_send : st_listen; // RULE13 RULE22
              pending_payload_ack <= rx_ack_has_payload && !rx_skip_ack;
            end else begin
              state <= st_idle;
            end
          end
        end
        st_backoff: begin
          if (retry_count >= retry_limit) begin
            state <= st_idle;
          end else begin
            retry_count <= retry_count + 4'h1;
            state <= st_send; // RULE16
          end
        end
        st_ack_send: begin
          if (tx_done) begin
            state <= st_listen;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### design/radio_link_pkg.sv
// Constants for the multi-pipe auto-acknowledge link sequencer.
// Assumes a 200 MHz system clock; no timescale in packages.
package radio_link_pkg;
  // ==========================================
  // Register offsets (byte addresses)
  localparam logic [5:0] control_off = 6'h00;
  localparam logic [5:0] pipe_enable_off = 6'h04;
  localparam logic [5:0] pipe_zero_addr_lo_off = 6'h08;
  localparam logic [5:0] pipe_zero_addr_hi_off = 6'h0c;
  localparam logic [5:0] shared_addr_off = 6'h10;
  localparam logic [5:0] pipe_lsb_off = 6'h14;
  localparam logic [5:0] tx_addr_lo_off = 6'h18;
  localparam logic [5:0] tx_addr_hi_off = 6'h1c;
  localparam logic [5:0] status_off = 6'h20;
  localparam logic [5:0] ack_addr_lo_off = 6'h24;
  localparam logic [5:0] ack_addr_hi_off = 6'h28;
  localparam logic [5:0] wait_cfg_off = 6'h2c;
  // ==========================================
  // Control field positions
  localparam int ctl_chip_enable = 0;
  localparam int ctl_primary_rx = 1;
  localparam int ctl_auto_ack = 2;
  localparam int ctl_crc_on = 3;
  // Status field positions (bits 0-2 write one to clear)
  localparam int st_rx_data_ready = 0;
  localparam int st_tx_data_sent = 1;
  localparam int st_max_retry = 2;
  localparam int st_pipe_lo = 4;
  // ==========================================
  // Reset values
  localparam logic [5:0] pipe_enable_reset = 6'h03;
  localparam logic [31:0] control_reset = 32'h0000_0000;
  localparam logic [39:0] pipe_zero_reset = 40'he7e7e7e7e7;
  localparam logic [31:0] shared_reset = 32'hc2c2c2c2;
  localparam logic [7:0] pipe_lsb_reset = 8'hc2;
  localparam logic [31:0] wait_cfg_reset = 32'h0000_0003;
  // ==========================================
  // Timing
  localparam int clk_mhz = 200;
  localparam int ce_min_us = 10;
  localparam int settle_us = 130;
  localparam int ce_min_cycles = ce_min_us * clk_mhz;
  localparam int settle_cycles = settle_us * clk_mhz;
  localparam int retry_step_us = 250;
  localparam int retry_step_cycles = retry_step_us * clk_mhz;
  // ==========================================
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_settle = 3'b001,
    st_send = 3'b011,
    st_listen = 3'b010,
    st_receive = 3'b110,
    st_backoff = 3'b111,
    st_ack_send = 3'b101
  } link_state_type;
endpackage
